/* File: hdl/qsas_pkg.sv */
/*
 Shared constants and types for the quad serial add/subtract block.
 Assumes a single 50 MHz clock domain and a plain register port.
*/
package qsas_pkg;

    // Datapath shape
    localparam int NumSlices = 4;
    localparam int WordBits = 8;
    localparam int CountBits = 3;
    localparam int FifoWidth = 32;
    localparam int FifoDepth = 8;
    localparam int LevelBits = 4;

    // Clock
    localparam int ClkPeriodNs = 20;

    // Register byte addresses
    localparam logic [7:0] AddrCtrl = 8'h00;
    localparam logic [7:0] AddrStatus = 8'h04;
    localparam logic [7:0] AddrData = 8'h08;
    localparam logic [7:0] AddrLive = 8'h0c;
    localparam logic [7:0] AddrWords = 8'h10;

    // Control fields
    localparam int CtrlCapEnBit = 0;
    localparam int CtrlFlushBit = 1;
    localparam logic CtrlCapEnReset = 1'b0;

    // Status fields
    localparam int StatEmptyBit = 0;
    localparam int StatFullBit = 1;
    localparam int StatOverrunBit = 2;
    localparam int StatPendBit = 3;
    localparam int StatLevelLsb = 4;

    // Live view fields
    localparam int LiveSumLsb = 0;
    localparam int LiveCarryLsb = 4;
    localparam int LiveSelLsb = 8;
    localparam int LiveClearBit = 12;

    // Operand pins of all four slices
    typedef struct packed {
        logic [NumSlices-1:0] opA;
        logic [NumSlices-1:0] opB;
        logic [NumSlices-1:0] sel;
    } qsas_operand_s;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } qsas_bus_s;

    // Capture engine states
    typedef enum logic [2:0] {
        CapIdle = 3'b001,
        CapRun = 3'b010,
        CapHold = 3'b100
    } qsas_cap_e;

endpackage : qsas_pkg

/* File: hdl/qsas_slice.sv */
/*
 One bit-serial adder/subtractor slice: a sum flip-flop and a carry flip-flop.
 Assumes operands arrive LSB first, one bit per rising clock edge.
*/
`timescale 1ns/1ps
module qsas_slice (
    // Clock and clear
    input wire logic clk,
    input wire logic clearN,
    // Operands and mode
    input wire logic opA,
    input wire logic opB,
    input wire logic sel,
    // State
    output logic sumReg,
    output logic carryReg
);

    logic effB;
    logic sumNext;
    logic carryNext;
    logic clrAddN;
    logic clrSubN;

    // Operand B inverted when subtracting
    assign effB = opB ^ sel; // RULE7
    assign sumNext = opA ^ effB ^ carryReg; // RULE10
    assign carryNext = (opA & effB) | (opA & carryReg) | (effB & carryReg); // RULE11
    // Clear splits by mode into a zero path and a one path
    assign clrAddN = clearN | sel; // RULE6
    assign clrSubN = clearN | ~sel; // RULE6

    // Sum flip-flop, cleared at once by clear
    always_ff @(posedge clk or negedge clearN) // RULE5
    begin
        if (!clearN)
            sumReg <= 1'b0; // RULE6
        else
            sumReg <= sumNext; // RULE2
    end

    // Carry flip-flop, zero for add and one for subtract under clear
    always_ff @(posedge clk or negedge clrAddN or negedge clrSubN) // RULE5
    begin
        if (!clrAddN)
            carryReg <= 1'b0;
        else if (!clrSubN)
            carryReg <= 1'b1; // RULE8
        else
            carryReg <= carryNext; // RULE2
    end

endmodule : qsas_slice

/* File: hdl/qsas_fifo.sv */
/*
 Small synchronous FIFO with a registered output stage.
 Assumes one clock; flush empties it in one cycle.
*/
`timescale 1ns/1ps
module qsas_fifo #(
    parameter int Width = 32,
    parameter int Depth = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic flush,
    // Fill side
    input wire logic [Width-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // Drain side
    output logic [Width-1:0] outData,
    output logic outValid,
    input wire logic outReady,
    // Occupancy, output stage included
    output logic [$clog2(Depth+1)-1:0] level
);

    localparam int PtrBits = $clog2(Depth);
    localparam int CntBits = $clog2(Depth+1);

    logic [Width-1:0] mem [Depth];
    logic [PtrBits-1:0] wrPtr;
    logic [PtrBits-1:0] rdPtr;
    logic [CntBits-1:0] count;
    logic doPush;
    logic doLoad;

    // Handshake decode
    assign inReady = (count != CntBits'(Depth));
    assign doPush = inValid & inReady;
    assign doLoad = (count != '0) & (~outValid | outReady);
    assign level = count + CntBits'(outValid); // Depth plus one still fits

    // Storage array
    always_ff @(posedge clk)
    begin
        if (doPush)
            mem[wrPtr] <= inData;
    end

    // Pointers, count and output register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            outValid <= 1'b0;
            outData <= '0;
        end
        else if (flush)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            outValid <= 1'b0;
        end
        else
        begin
            if (doPush)
                wrPtr <= PtrBits'((wrPtr + 1'b1) % Depth);
            if (doLoad)
            begin
                outData <= mem[rdPtr];
                rdPtr <= PtrBits'((rdPtr + 1'b1) % Depth);
                outValid <= 1'b1;
            end
            else if (outReady)
                outValid <= 1'b0;
            count <= CntBits'(count + CntBits'(doPush) - CntBits'(doLoad));
        end
    end

endmodule : qsas_fifo

/* File: hdl/qsas_top.sv */
/*
 Quad serial add/subtract block: four serial slices, a capture engine that
 gathers result words into a FIFO, and a small register port.
 Assumes operand pins are synchronous to clk and the register master follows
 the one-cycle strobe protocol with read data one cycle later.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
// How it works
// RULE1: Four separate slices share clk and the clear, each with own A, B and select.
// RULE2: Each slice keeps its result bit and carry in flops that change on the rising edge.
// RULE3: Select low adds the operands, select high subtracts B from A.
// RULE4: Results are correct for twos complement operands in both modes.
// RULE5: The active-low master clear acts at once, without a clock edge.
// RULE6: Under clear the result bit is zero and the carry equals the select.
// RULE7: When subtracting, operand B is inverted inside the slice.
// RULE8: A carry preset to one enters the first LSB operation after clear release.
// RULE9: For ones complement, the source keeps select low in clear and raises it before the next edge.
// RULE10: Each edge stores A xor effective B xor carry as the result bit.
// RULE11: Each edge stores the majority of A, effective B and carry as the new carry.
// RULE12: Ones complement and unsigned use come from the same datapath and carry start.
// RULE13: The source gives one bit pair per clock, LSB first, and holds select for a word.
// RULE14: Each result output comes straight from its result flop.
`timescale 1ns/1ps
module qsas_top (
    // Clock and resets
    input wire logic clk,
    input wire logic nrst,
    input wire logic master_clear_n,
    // Operand streams
    input wire qsas_pkg::qsas_operand_s operands,
    // Serial results
    output logic [qsas_pkg::NumSlices-1:0] results,
    // Register port
    input wire qsas_pkg::qsas_bus_s bus,
    output logic [31:0] rdata
);

    // Combined clear for the slices
    logic clearN;
    logic [qsas_pkg::NumSlices-1:0] sumBits;
    logic [qsas_pkg::NumSlices-1:0] carryBits;

    // Capture engine
    qsas_pkg::qsas_cap_e capState_reg;
    qsas_pkg::qsas_cap_e capState_next;
    logic streamLive_reg;
    logic [qsas_pkg::CountBits-1:0] bitCount_reg;
    logic [qsas_pkg::WordBits-1:0] shift_reg [qsas_pkg::NumSlices];
    logic [qsas_pkg::FifoWidth-1:0] assembled;
    logic [qsas_pkg::FifoWidth-1:0] pend_reg;
    logic wordDone;
    logic pushNow;
    logic dropWord;

    // Registers
    logic capEn_reg;
    logic overrun_reg;
    logic overrun_next;
    logic flush_reg;
    logic [15:0] words_reg;

    // FIFO wiring
    logic fifoInReady;
    logic fifoInValid;
    logic [qsas_pkg::FifoWidth-1:0] fifoOutData;
    logic fifoOutValid;
    logic fifoPop;
    logic [qsas_pkg::LevelBits-1:0] fifoLevel;

    // Bus decode
    logic hitCtrl;
    logic hitStatus;
    logic hitData;
    logic hitLive;
    logic hitWords;
    logic [31:0] ctrlView;
    logic [31:0] statusView;
    logic [31:0] dataView;
    logic [31:0] liveView;
    logic [31:0] wordsView;
    logic [31:0] rdata_next;

    // Either reset clears the slices immediately
    assign clearN = nrst & master_clear_n; // RULE5

    // One slice per operand pair
    generate
        for (genvar s = 0; s < qsas_pkg::NumSlices; s++)
        begin : g_slice
            qsas_slice u_slice (
                .clk(clk),
                .clearN(clearN),
                .opA(operands.opA[s]),
                .opB(operands.opB[s]),
                .sel(operands.sel[s]),
                .sumReg(sumBits[s]),
                .carryReg(carryBits[s])
            ); // RULE1 RULE3 RULE4 RULE12

            // Deserialiser, LSB arrives first and shifts down
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                    shift_reg[s] <= '0;
                else if (streamLive_reg && capEn_reg)
                    shift_reg[s] <= {sumBits[s], shift_reg[s][qsas_pkg::WordBits-1:1]};
            end

            // Word lane of this slice in the FIFO entry
            assign assembled[s*qsas_pkg::WordBits +: qsas_pkg::WordBits] =
                {sumBits[s], shift_reg[s][qsas_pkg::WordBits-1:1]};
        end
    endgenerate

    // Result pins are the sum flops themselves
    assign results = sumBits; // RULE14

    // Sum flops hold a real result from the first edge after clear
    always_ff @(posedge clk or negedge clearN)
    begin
        if (!clearN)
            streamLive_reg <= 1'b0;
        else
            streamLive_reg <= 1'b1;
    end

    // Bit position within the current word, aligned to clear release
    always_ff @(posedge clk or negedge clearN)
    begin
        if (!clearN)
            bitCount_reg <= '0;
        else if (streamLive_reg && capEn_reg)
            bitCount_reg <= qsas_pkg::CountBits'(bitCount_reg + 1'b1);
    end

    // Word completes on the last bit of the lane
    assign wordDone = streamLive_reg && capEn_reg &&
        (bitCount_reg == qsas_pkg::CountBits'(qsas_pkg::WordBits - 1));

    // FIFO gets the pending word while in hold
    assign fifoInValid = (capState_reg == qsas_pkg::CapHold);
    assign pushNow = fifoInValid & fifoInReady;
    // A finished word with no free pending slot is lost
    assign dropWord = wordDone && fifoInValid && !fifoInReady;

    // Capture state sequencing
    always_comb
    begin
        capState_next = capState_reg;
        unique case (capState_reg)
            qsas_pkg::CapIdle:
            begin
                if (capEn_reg)
                    capState_next = qsas_pkg::CapRun;
            end
            qsas_pkg::CapRun:
            begin
                if (wordDone)
                    capState_next = qsas_pkg::CapHold;
                else if (!capEn_reg)
                    capState_next = qsas_pkg::CapIdle;
            end
            qsas_pkg::CapHold:
            begin
                if (pushNow && wordDone)
                    capState_next = qsas_pkg::CapHold;
                else if (pushNow)
                    capState_next = capEn_reg ? qsas_pkg::CapRun : qsas_pkg::CapIdle;
            end
            default:
                capState_next = qsas_pkg::CapIdle;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            capState_reg <= qsas_pkg::CapIdle;
        else if (flush_reg)
            capState_reg <= qsas_pkg::CapIdle;
        else
            capState_reg <= capState_next;
    end

    // Pending word waits here while the FIFO is full
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pend_reg <= '0;
        else if (wordDone && (!fifoInValid || pushNow))
            pend_reg <= assembled;
    end

    // Words handed to the FIFO, wraps
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            words_reg <= '0;
        else if (pushNow)
            words_reg <= words_reg + 16'h0001;
    end

    // The buffer between the capture engine and software
    qsas_fifo #(
        .Width(qsas_pkg::FifoWidth),
        .Depth(qsas_pkg::FifoDepth)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .flush(flush_reg),
        .inData(pend_reg),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .outData(fifoOutData),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .level(fifoLevel)
    );

    // Address decode
    assign hitCtrl = (bus.addr == qsas_pkg::AddrCtrl);
    assign hitStatus = (bus.addr == qsas_pkg::AddrStatus);
    assign hitData = (bus.addr == qsas_pkg::AddrData);
    assign hitLive = (bus.addr == qsas_pkg::AddrLive);
    assign hitWords = (bus.addr == qsas_pkg::AddrWords);

    // A data read consumes the head word
    assign fifoPop = bus.rd & hitData & fifoOutValid;

    // Control register, capture enable
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            capEn_reg <= qsas_pkg::CtrlCapEnReset;
        else if (bus.wr && hitCtrl)
            capEn_reg <= bus.wdata[qsas_pkg::CtrlCapEnBit];
    end

    // Flush is a one-cycle pulse from a control write
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            flush_reg <= 1'b0;
        else
            flush_reg <= bus.wr & hitCtrl & bus.wdata[qsas_pkg::CtrlFlushBit];
    end

    // Overrun is sticky, write one clears, a new loss wins
    always_comb
    begin
        overrun_next = overrun_reg;
        if (bus.wr && hitStatus && bus.wdata[qsas_pkg::StatOverrunBit])
            overrun_next = 1'b0;
        if (dropWord)
            overrun_next = 1'b1;
    end

    // Overrun flag
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            overrun_reg <= 1'b0;
        else
            overrun_reg <= overrun_next;
    end

    // Read views
    assign ctrlView = {30'h0, 1'b0, capEn_reg};
    assign statusView = {24'h0, fifoLevel, fifoInValid, overrun_reg,
        ~fifoInReady, ~fifoOutValid};
    assign dataView = fifoOutValid ? fifoOutData : 32'h0;
    assign liveView = {19'h0, ~clearN, operands.sel, carryBits, sumBits};
    assign wordsView = {16'h0, words_reg};

    // Read multiplexer, unmapped reads give zero
    assign rdata_next = !bus.rd ? 32'h0 :
        hitCtrl ? ctrlView :
        hitStatus ? statusView :
        hitData ? dataView :
        hitLive ? liveView :
        hitWords ? wordsView : 32'h0;

    // Read data stand one cycle after the strobe
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata <= 32'h0;
        else
            rdata <= rdata_next;
    end

endmodule : qsas_top

/* File: test/qsas_chk.sv */
/*
 Checker for the quad serial add/subtract top, bound to its ports.
 Assumes one clock domain and the read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
module qsas_chk (
    // Clock and resets
    input wire logic clk,
    input wire logic nrst,
    input wire logic master_clear_n,
    // Slice side
    input wire qsas_pkg::qsas_operand_s operands,
    input wire logic [qsas_pkg::NumSlices-1:0] results,
    // Register port
    input wire qsas_pkg::qsas_bus_s bus,
    input wire logic [31:0] rdata
);
    logic clrN;
    logic liveRd;
    logic [3:0] effB;
    logic [3:0] maj;
    logic [3:0] carryM;
    logic [3:0] carryQ;

    // Combined clear, effective operand B and next carry
    assign clrN = nrst & master_clear_n;
    assign liveRd = bus.rd && bus.addr == qsas_pkg::AddrLive;
    assign effB = operands.opB ^ operands.sel;
    assign maj = (operands.opA & effB) | (operands.opA & carryM) | (effB & carryM);

    // Reference carry, follows select at once while cleared
    assign carryM = clrN ? carryQ : operands.sel;

    // Reference carry flop, holds the preset through the release
    always_ff @(posedge clk)
    begin
        carryQ <= clrN ? maj : operands.sel;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Clear released with select held
    sequence released;
        !master_clear_n ##1 (master_clear_n && $stable(operands.sel));
    endsequence

    a_clear_zero_sum: assert property (!master_clear_n |-> results == '0)
        else $error("sum not zero under clear");
    a_clear_acts_now: assert property ($fell(master_clear_n) |-> results == '0)
        else $error("clear did not act at once");
    a_sum_of_bits: assert property (clrN ##1 clrN |->
        results == $past(operands.opA ^ effB ^ carryM))
        else $error("sum bit wrong");
    a_first_bit_preset: assert property (released |=>
        results == $past(operands.opA ^ operands.opB))
        else $error("first bit ignores preset carry");
    a_live_view: assert property (liveRd |=>
        rdata[12:0] == $past({~master_clear_n, operands.sel, carryM, results}))
        else $error("live view mismatch");
    a_carry_in_clear: assert property (!master_clear_n && liveRd |=>
        rdata[7:4] == $past(operands.sel))
        else $error("carry not preset from select");
    a_read_one_cycle: assert property (!$past(bus.rd) |-> rdata == '0)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (bus.rd && bus.addr > qsas_pkg::AddrWords |=> rdata == '0)
        else $error("unmapped read not zero");
endmodule : qsas_chk

bind qsas_top qsas_chk chkInst (
    .clk(clk),
    .nrst(nrst),
    .master_clear_n(master_clear_n),
    .operands(operands),
    .results(results),
    .bus(bus),
    .rdata(rdata)
);

/* File: test/qsas_src_model.sv */
/*
 Serial operand source: shifts four 8-bit lanes out LSB first.
 Assumes start is a one-cycle pulse; lines toggle when idle.
*/
`timescale 1ns/1ps
module qsas_src_model (
    // Clock and control
    input wire logic clk,
    input wire logic start,
    // Words, lane s feeds slice s
    input wire logic [31:0] wordA,
    input wire logic [31:0] wordB,
    // Serial bits
    output logic [3:0] bitA,
    output logic [3:0] bitB
);
    logic [31:0] shA = '0;
    logic [31:0] shB = '0;
    logic [3:0] left = '0;

    // One bit pair per clock, LSB first; idle lines toggle
    always @(posedge clk)
    begin
        if (start)
        begin
            shA <= wordA;
            shB <= wordB;
            left <= 4'h8;
        end
        else if (left != 4'h0)
        begin
            shA <= shA >> 1;
            shB <= shB >> 1;
            left <= left - 4'h1;
        end
        else
        begin
            shA <= ~shA;
            shB <= ~shB;
        end
    end

    // Bit 0 of each lane
    assign bitA = {shA[24], shA[16], shA[8], shA[0]};
    assign bitB = {shB[24], shB[16], shB[8], shB[0]};
endmodule : qsas_src_model

/* File: test/testbench.sv */
/*
 Self-checking bench for the quad serial add/subtract top.
 Assumes the source model, the checker bind and the register map of the block.
*/
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic masterClearN = 1'b0;
    logic start = 1'b0;
    logic [3:0] selV = '0;
    logic [31:0] wordA = '0;
    logic [31:0] wordB = '0;
    logic [3:0] bitA;
    logic [3:0] bitB;
    logic [3:0] results;
    logic [31:0] rdata;
    qsas_pkg::qsas_bus_s bus = '0;
    qsas_pkg::qsas_operand_s operands;
    int badCount = 0;
    int checksDone = 0;
    int cycles = 0;

    assign operands = {bitA, bitB, selV};

    qsas_src_model src (.clk(clk), .start(start), .wordA(wordA), .wordB(wordB),
        .bitA(bitA), .bitB(bitB));
    qsas_top dut (.clk(clk), .nrst(nrst), .master_clear_n(masterClearN),
        .operands(operands), .results(results), .bus(bus), .rdata(rdata));

    // Clock
    initial
    begin
        forever #(qsas_pkg::ClkPeriodNs / 2) clk = ~clk;
    end

    task automatic finalReport();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finalReport

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            badCount++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= {a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus <= {a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        d = rdata;
    endtask : rd

    // One serial word per slice, checked at the pins and in the FIFO
    task automatic runWord(input logic [31:0] a, input logic [31:0] b, input logic [3:0] m,
        input logic ones);
        logic [31:0] got;
        logic [31:0] exp;
        logic [31:0] d;
        for (int s = 0; s < 4; s++)
            exp[8*s+:8] = ones ? a[8*s+:8] + ~b[8*s+:8] :
                m[s] ? a[8*s+:8] - b[8*s+:8] : a[8*s+:8] + b[8*s+:8];
        @(posedge clk);
        masterClearN <= 1'b0;
        selV <= ones ? 4'h0 : m;
        wordA <= a;
        wordB <= b;
        wr(qsas_pkg::AddrCtrl, 32'h3);
        rd(qsas_pkg::AddrLive, d);
        chk(d, {19'h0, 1'b1, selV, selV, 4'h0});
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        masterClearN <= 1'b1;
        if (ones)
        begin
            @(negedge clk);
            selV <= m;
        end
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk);
            #1;
            for (int s = 0; s < 4; s++)
                got[8*s+k] = results[s];
        end
        chk(got, exp);
        @(posedge clk);
        masterClearN <= 1'b0;
        d = 32'h1;
        for (int i = 0; i < 8 && d[0] !== 1'b0; i++)
            rd(qsas_pkg::AddrStatus, d);
        rd(qsas_pkg::AddrData, d);
        chk(d, exp);
    endtask : runWord

    // Fill the FIFO to overrun, drain it, clear the sticky flag
    task automatic fillDrain();
        logic [31:0] d;
        wr(qsas_pkg::AddrCtrl, 32'h3);
        @(posedge clk);
        masterClearN <= 1'b1;
        repeat (120) @(posedge clk);
        rd(qsas_pkg::AddrStatus, d);
        chk(d, 32'h9e);
        wr(qsas_pkg::AddrCtrl, 32'h0);
        @(posedge clk);
        masterClearN <= 1'b0;
        for (int i = 0; i < 12; i++)
            rd(qsas_pkg::AddrData, d);
        rd(qsas_pkg::AddrStatus, d);
        chk(d, 32'h5);
        rd(qsas_pkg::AddrWords, d);
        chk(d, 32'he);
        wr(qsas_pkg::AddrStatus, 32'h4);
        rd(qsas_pkg::AddrStatus, d);
        chk(d & 32'h4, 32'h0);
        rd(8'h14, d);
        chk(d, 32'h0);
        rd(qsas_pkg::AddrCtrl, d);
        chk(d, 32'h0);
    endtask : fillDrain

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        runWord(32'h7f8001ff, 32'h017fff01, 4'h0, 1'b0);
        runWord(32'h7f8001ff, 32'h017fff01, 4'hf, 1'b0);
        runWord(32'h00558010, 32'h01aa7f20, 4'ha, 1'b0);
        runWord(32'h00558010, 32'h01aa7f20, 4'hf, 1'b1);
        fillDrain();
        finalReport();
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            badCount++;
            finalReport();
        end
    end
endmodule : testbench
